// File: ips_pkg.sv
// package: register map, field positions and reset values of the level select
package ips_pkg;
  localparam logic [31:0] LEVEL_SELECT_ADDR = 32'h0000_0000;
  localparam logic [31:0] ADDR_MASK = 32'h0000_00FC;
  localparam int EXT_ZERO_POS = 0;
  localparam int TIMER_ZERO_POS = 1;
  localparam int EXT_ONE_POS = 2;
  localparam int TIMER_ONE_POS = 3;
  localparam int UART_POS = 4;
  localparam int TIMER_TWO_POS = 5;
  localparam int SPI_POS = 6;
  localparam int UNUSED_POS = 7;
  localparam logic [7:0] LEVEL_RESET = 8'h80;
  localparam logic [7:0] LEVEL_WMASK = 8'h7F;
  localparam logic [7:0] LEVEL_ONES = 8'h80;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int NUM_SOURCES = 7;
endpackage

// File: ips_level_reg.sv
// level select register: byte lane 0 write with per-bit mask and readback
`timescale 1ns/10ps
module ips_level_reg (
  input wire logic clk,
  input wire logic reset,
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  output logic [7:0] level
);
  logic [7:0] next_level;

  always_comb begin
    next_level = level;
    if (wr_en) begin
      // top bit always reads one and ignores writes
      next_level = (wr_data & ips_pkg::LEVEL_WMASK) | ips_pkg::LEVEL_ONES;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      level <= ips_pkg::LEVEL_RESET;
    end else begin
      level <= next_level;
    end
  end
endmodule // ips_level_reg

// File: ips_top.sv
// interrupt level select block with an AXI4-Lite register slave
// Behaviour
// R01 - the uart source is high level when its bit 4 is one, else low.
// R02 - bit 3 sets timer one to high level when one, low when zero.
// R03 - bit 1 sets timer zero to high level when one, low when zero.
// R04 - bit 0 sets external interrupt zero to high level when one, else low.
// R05 - bit 2 sets external interrupt one to high level when one, else low.
// R06 - bit 6 sets the serial peripheral source to high level when one.
`timescale 1ns/10ps
module ips_top (
  input wire logic clk,
  input wire logic reset,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic uart_level_bit,
  output logic timer_one_level_bit,
  output logic ext_irq_one_level_bit,
  output logic timer_zero_level_bit,
  output logic ext_irq_zero_level_bit,
  output logic timer_two_level_bit,
  output logic serial_periph_level_bit
);
  // ****************************************
  // write channel
  // ****************************************
  logic aw_held;
  logic [31:0] aw_addr;
  logic w_held;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic next_aw_held;
  logic [31:0] next_aw_addr;
  logic next_w_held;
  logic [31:0] next_w_data;
  logic [3:0] next_w_strb;
  logic next_bvalid;
  logic [1:0] next_bresp;
  logic do_write;
  logic wr_hit;
  logic wr_en;
  logic [7:0] interrupt_level_select;

  // address and data are taken in either order; response follows both
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign wr_hit = (aw_addr & ips_pkg::ADDR_MASK) ==
                  ips_pkg::LEVEL_SELECT_ADDR;
  // only lane 0 carries the byte; other lanes are ignored
  assign wr_en = do_write && wr_hit && w_strb[0];

  always_comb begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held = w_held;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = wr_hit ? ips_pkg::RESP_OKAY : ips_pkg::RESP_SLVERR;
    end else if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      aw_held <= 1'b0;
      aw_addr <= 32'h0000_0000;
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      aw_held <= next_aw_held;
      aw_addr <= next_aw_addr;
      w_held <= next_w_held;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
    end
  end

  ips_level_reg u_level (
    .clk(clk),
    .reset(reset),
    .wr_en(wr_en),
    .wr_data(w_data[7:0]),
    .level(interrupt_level_select)
  );

  // ****************************************
  // read channel
  // ****************************************
  logic next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;
  logic rd_hit;

  assign s_axi_arready = !s_axi_rvalid;
  assign rd_hit = (s_axi_araddr & ips_pkg::ADDR_MASK) ==
                  ips_pkg::LEVEL_SELECT_ADDR;

  always_comb begin
    next_rvalid = s_axi_rvalid;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rdata = rd_hit ? {24'h00_0000, interrupt_level_select}
                          : 32'h0000_0000;
      next_rresp = rd_hit ? ips_pkg::RESP_OKAY : ips_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end else begin
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
    end
  end

  // ****************************************
  // level outputs to the arbitration logic
  // ****************************************
  // one is high level, zero is low level for every source
  assign uart_level_bit =
    interrupt_level_select[ips_pkg::UART_POS]; // see R01
  assign timer_one_level_bit =
    interrupt_level_select[ips_pkg::TIMER_ONE_POS]; // see R02
  assign timer_zero_level_bit =
    interrupt_level_select[ips_pkg::TIMER_ZERO_POS]; // see R03
  assign ext_irq_zero_level_bit =
    interrupt_level_select[ips_pkg::EXT_ZERO_POS]; // see R04
  assign ext_irq_one_level_bit =
    interrupt_level_select[ips_pkg::EXT_ONE_POS]; // see R05
  assign serial_periph_level_bit =
    interrupt_level_select[ips_pkg::SPI_POS]; // see R06
  assign timer_two_level_bit = interrupt_level_select[ips_pkg::TIMER_TWO_POS];

  // ****************************************
  // checks
  // ****************************************
  sequence seq_write_bit(int pos, logic val);
    wr_en && (w_data[pos] == val);
  endsequence

  AST_UART_LEVEL: assert property ( // see R01
    @(posedge clk) disable iff (reset)
    seq_write_bit(ips_pkg::UART_POS, 1'b1) |=> uart_level_bit)
    else $error("uart level not raised by write");
  AST_TIMER_ONE_LEVEL: assert property ( // see R02
    @(posedge clk) disable iff (reset)
    seq_write_bit(ips_pkg::TIMER_ONE_POS, 1'b0) |=> !timer_one_level_bit)
    else $error("timer one level not cleared");
  AST_TIMER_ONE_SET: assert property ( // see R02
    @(posedge clk) disable iff (reset)
    seq_write_bit(ips_pkg::TIMER_ONE_POS, 1'b1) |=> timer_one_level_bit)
    else $error("timer one level not raised");
  AST_TIMER_ZERO_LEVEL: assert property ( // see R03
    @(posedge clk) disable iff (reset)
    seq_write_bit(ips_pkg::TIMER_ZERO_POS, 1'b1) |=> timer_zero_level_bit)
    else $error("timer zero level not raised");
  AST_EXT_ZERO_LEVEL: assert property ( // see R04
    @(posedge clk) disable iff (reset)
    !wr_en |=> $stable(ext_irq_zero_level_bit))
    else $error("ext zero level changed without write");
  AST_EXT_ZERO_SET: assert property ( // see R04
    @(posedge clk) disable iff (reset)
    seq_write_bit(ips_pkg::EXT_ZERO_POS, 1'b1) |=> ext_irq_zero_level_bit)
    else $error("ext zero level not raised");
  AST_EXT_ONE_LEVEL: assert property ( // see R05
    @(posedge clk) disable iff (reset)
    seq_write_bit(ips_pkg::EXT_ONE_POS, 1'b1) |=> ext_irq_one_level_bit)
    else $error("ext one level not raised");
  AST_SPI_LEVEL: assert property ( // see R06
    @(posedge clk) disable iff (reset)
    seq_write_bit(ips_pkg::SPI_POS, 1'b0) |=> !serial_periph_level_bit)
    else $error("spi level not cleared");
  AST_READBACK: assert property ( // see R01
    @(posedge clk) disable iff (reset)
    s_axi_arvalid && s_axi_arready && rd_hit |=>
    s_axi_rdata[6:0] == $past(interrupt_level_select[6:0])
    && s_axi_rdata[7])
    else $error("readback mismatch");
  AST_WRITE_RESP: assert property ( // see R04
    @(posedge clk) disable iff (reset)
    do_write |=> s_axi_bvalid)
    else $error("write response missing");
endmodule // ips_top

// File: ips_core_model.sv
// partner model: core arbitration side collecting the level selects
`timescale 1ns/10ps
module ips_core_model (
  input wire logic uart_level_bit,
  input wire logic timer_one_level_bit,
  input wire logic ext_irq_one_level_bit,
  input wire logic timer_zero_level_bit,
  input wire logic ext_irq_zero_level_bit,
  input wire logic timer_two_level_bit,
  input wire logic serial_periph_level_bit,
  output logic [6:0] level_vec
);
  // packed in register bit order so the bench compares one word; 1 = high
  assign level_vec = {serial_periph_level_bit, timer_two_level_bit,
    uart_level_bit, timer_one_level_bit, ext_irq_one_level_bit,
    timer_zero_level_bit,
    ext_irq_zero_level_bit};
endmodule // ips_core_model

// File: interrupt_priority_select_test.sv
// testbench: level select writes, readback and level outputs
`timescale 1ns/10ps
module interrupt_priority_select_test;
  logic clk = 1'h0;
  logic reset = 1'h1;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata, got, d, a;
  logic [31:0] seed = 32'hEF719EC7;
  logic [3:0] wstrb = 4'h0, s;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic arvalid = 1'h0, rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, resp;
  logic [6:0] lv;
  logic uart, t1, x1, t0, x0, t2, spi;
  logic [7:0] mdl = ips_pkg::LEVEL_RESET;
  int err_count = 0;
  int n_tests = 0;
  ips_top u_ips_top (.clk(clk), .reset(reset), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .uart_level_bit(uart), .timer_one_level_bit(t1),
    .ext_irq_one_level_bit(x1), .timer_zero_level_bit(t0),
    .ext_irq_zero_level_bit(x0), .timer_two_level_bit(t2),
    .serial_periph_level_bit(spi));
  ips_core_model u_ips_core_model (.uart_level_bit(uart),
    .timer_one_level_bit(t1), .ext_irq_one_level_bit(x1),
    .timer_zero_level_bit(t0), .ext_irq_zero_level_bit(x0),
    .timer_two_level_bit(t2), .serial_periph_level_bit(spi),
    .level_vec(lv));
  initial begin
    forever #20 clk = ~clk;
  end
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", n, e, g);
      err_count++;
    end
  endtask
  // inputs are steady between rising edges, so the falling edge sees
  // exactly what the next rising edge will sample
  task automatic wr(logic [31:0] ad, logic [31:0] dt, logic [3:0] st);
    logic ta, tw, tb;
    awaddr <= ad;
    wdata <= dt;
    wstrb <= st;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(negedge clk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      resp = bresp;
      @(posedge clk);
      if (ta) awvalid <= 1'h0;
      if (tw) wvalid <= 1'h0;
    end while (!tb);
    bready <= 1'h0;
    @(posedge clk);
  endtask
  task automatic rd(logic [31:0] ad);
    logic ta, tr;
    araddr <= ad;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(negedge clk);
      ta = arvalid && arready;
      tr = rvalid;
      got = rdata;
      resp = rresp;
      @(posedge clk);
      if (ta) arvalid <= 1'h0;
    end while (!tr);
    rready <= 1'h0;
    @(posedge clk);
  endtask
  function automatic logic [7:0] nxt(logic [7:0] m, logic [31:0] ad,
    logic [31:0] dt, logic [3:0] st);
    if (ad != ips_pkg::LEVEL_SELECT_ADDR || !st[0]) return m;
    return (dt[7:0] & ips_pkg::LEVEL_WMASK) | ips_pkg::LEVEL_ONES;
  endfunction
  task automatic step(logic [31:0] ad, logic [31:0] dt, logic [3:0] st);
    logic ok;
    ok = (ad == ips_pkg::LEVEL_SELECT_ADDR);
    wr(ad, dt, st);
    chk("bresp", 32'(ok ? ips_pkg::RESP_OKAY : ips_pkg::RESP_SLVERR),
      32'(resp));
    mdl = nxt(mdl, ad, dt, st);
    rd(ad);
    chk("rdata", ok ? {24'h0, mdl} : 32'h0, got);
    chk("rresp", 32'(ok ? ips_pkg::RESP_OKAY : ips_pkg::RESP_SLVERR),
      32'(resp));
    chk("levels", 32'(mdl[6:0]), 32'(lv));
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (20) @(posedge clk);
    reset <= 1'h0;
    @(posedge clk);
    rd(32'h0);
    chk("reset", {24'h0, ips_pkg::LEVEL_RESET}, got);
    chk("reset levels", 32'h0, {25'h0, lv});
    for (int i = 0; i < 8; i++) begin
      step(32'h0, 32'h1 << i, 4'hF);
    end
    step(32'h0, 32'h7F, 4'hF);
    step(32'h0, 32'h0, 4'hE);
    step(32'h10, 32'h0, 4'hF);
    // random mix: about half the register, half unmapped words, random strobes
    repeat (60) begin
      d = $random(seed);
      s = 4'($random(seed));
      a = d[31] ? {24'h0, d[7:2], 2'h0} : 32'h0;
      step(a, d, s);
    end
    // reset in mid-run must bring every level back to low
    reset <= 1'h1;
    repeat (3) @(posedge clk);
    reset <= 1'h0;
    mdl = ips_pkg::LEVEL_RESET;
    @(posedge clk);
    rd(32'h0);
    chk("reset again", {24'h0, ips_pkg::LEVEL_RESET}, got);
    chk("reset again levels", 32'h0, 32'(lv));
    step(32'h0, 32'h55, 4'h1);
    end_sim;
  end
  // about 145 transfers of a few cycles each; generous margin
  initial begin
    repeat (5000) @(posedge clk);
    err_count++;
    end_sim;
  end
endmodule // interrupt_priority_select_test
